/* rtl/cqf_top.sv */
`timescale 1ns/1ns
module cqf_top #(
  parameter int DATA_W = 128
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Configuration: 0 dword-aligned, 1 address-aligned
  input wire logic align_addr_in,
  // Received request headers, posted and non-posted
  input wire logic hdr_p_valid_in,
  input wire logic [cqf_pkg::HDR_W-1:0] hdr_p_in,
  output logic hdr_p_ready_out,
  input wire logic hdr_np_valid_in,
  input wire logic [cqf_pkg::HDR_W-1:0] hdr_np_in,
  output logic hdr_np_ready_out,
  // Received payload dwords of the request being framed
  input wire logic pld_valid_in,
  input wire logic [31:0] pld_data_in,
  output logic pld_ready_out,
  output logic pld_np_out,
  // Completer request port
  output logic [DATA_W-1:0] cq_tdata_out,
  output logic [DATA_W/32-1:0] cq_tkeep_out,
  output logic cq_tlast_out,
  output logic cq_tvalid_out,
  input wire logic cq_tready_in,
  // Non-posted credit
  input wire logic nonposted_credit_grant_in,
  output logic [cqf_pkg::CREDIT_W-1:0] np_credit_out,
  // Requester request port
  input wire logic [DATA_W-1:0] rq_tdata_in,
  input wire logic rq_tlast_in,
  input wire logic rq_tvalid_in,
  input wire logic [3:0] rq_order_tag_in,
  output logic rq_tready_out,
  // Completer completion port
  input wire logic [DATA_W-1:0] cc_tdata_in,
  input wire logic cc_tlast_in,
  input wire logic cc_tvalid_in,
  output logic cc_tready_out,
  // Merged transmit stream
  output logic [DATA_W-1:0] tx_tdata_out,
  output logic tx_tlast_out,
  output logic tx_tvalid_out,
  input wire logic tx_tready_in,
  // Order tag echo
  output logic [3:0] request_order_tag_out,
  output logic request_order_tag_valid
);
  localparam int NDW = DATA_W / 32;
  localparam int SW = $clog2(NDW);

  typedef enum logic [3:0] {
    CQ_IDLE = 4'h1, CQ_TAKE = 4'h2, CQ_DESC = 4'h4, CQ_PAY = 4'h8
  } cqf_cq_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h1, TX_RQ = 3'h2, TX_CC = 3'h4
  } cqf_tx_state_t;

  cqf_cq_state_t cq_state_r, cq_state_nxt;
  cqf_pkg::cqf_hdr_t cur_r, cur_nxt, hp, hn;
  logic take_np_r, take_np_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [SW-1:0] slot_r, slot_nxt;
  logic [10:0] rem_r, rem_nxt;
  logic [DATA_W-1:0] acc_data_r, acc_data_nxt, out_data_r, out_data_nxt;
  logic [NDW-1:0] acc_keep_r, acc_keep_nxt, out_keep_r, out_keep_nxt;
  logic out_last_r, out_last_nxt, out_valid_r, out_valid_nxt;
  logic [cqf_pkg::CREDIT_W-1:0] credit_r, credit_nxt;
  logic p_ready_r, p_ready_nxt, np_ready_r, np_ready_nxt, pld_ready_r, pld_ready_nxt;
  logic place, flush, last;
  logic [31:0] dw;
  logic [7:0] age;
  logic [63:0] aaddr;

  cqf_desc_if dif ();
  cqf_desc_fmt u_fmt (.d(dif.fmt));
  assign dif.hdr = cur_r;
  assign hp = cqf_pkg::cqf_hdr_t'(hdr_p_in);
  assign hn = cqf_pkg::cqf_hdr_t'(hdr_np_in);
  assign age = hn.seq - hp.seq; // Wrapping arrival stamps
  assign aaddr = dif.has_addr ? cur_r.addr : 64'h0;

  // Completer request framing, one dword per cycle
  always_comb begin
    cq_state_nxt = cq_state_r;
    cur_nxt = cur_r;
    take_np_nxt = take_np_r;
    idx_nxt = idx_r;
    slot_nxt = slot_r;
    rem_nxt = rem_r;
    acc_data_nxt = acc_data_r;
    acc_keep_nxt = acc_keep_r;
    out_data_nxt = out_data_r;
    out_keep_nxt = out_keep_r;
    out_last_nxt = out_last_r;
    out_valid_nxt = out_valid_r;
    credit_nxt = credit_r;
    place = 1'b0;
    flush = 1'b0;
    last = 1'b0;
    dw = 32'h0;
    if (nonposted_credit_grant_in && credit_r != cqf_pkg::CREDIT_MAX) begin
      credit_nxt = credit_r + 6'h01;
    end
    unique case (cq_state_r)
      CQ_IDLE: begin
        // Non-posted waits for credit; posted passes it then, else arrival order
        if (hdr_np_valid_in && credit_r != cqf_pkg::CREDIT_RST &&
            (!hdr_p_valid_in || age[7])) begin
          cq_state_nxt = CQ_TAKE;
          take_np_nxt = 1'b1;
        end else if (hdr_p_valid_in) begin
          cq_state_nxt = CQ_TAKE;
          take_np_nxt = 1'b0;
        end
      end
      CQ_TAKE: begin
        cur_nxt = take_np_r ? hn : hp;
        if (take_np_r) begin
          credit_nxt = credit_nxt - 6'h01;
        end
        idx_nxt = 2'h0;
        slot_nxt = '0;
        cq_state_nxt = CQ_DESC;
      end
      CQ_DESC: begin
        // Descriptor dwords land in byte lanes 0..15 of the packet
        if (!out_valid_r) begin
          place = 1'b1;
          dw = dif.desc[32*idx_r +: 32];
          idx_nxt = idx_r + 2'h1;
          slot_nxt = slot_r + 1'b1;
          flush = (slot_r == SW'(NDW - 1));
          if (idx_r == 2'h3) begin
            rem_nxt = dif.has_data ? cur_r.dwcnt : 11'h0;
            if (rem_nxt == 11'h0) begin
              flush = 1'b1;
              last = 1'b1;
              cq_state_nxt = CQ_IDLE;
            end else begin
              cq_state_nxt = CQ_PAY;
              // Dword mode simply continues at lane 16, byte A mod 4 inside it
              if (align_addr_in) begin
                flush = 1'b1;
                slot_nxt = aaddr[SW+1:2];
              end
            end
          end
        end
      end
      CQ_PAY: begin
        if (pld_valid_in && pld_ready_r) begin
          place = 1'b1;
          dw = pld_data_in;
          rem_nxt = rem_r - 11'h1;
          slot_nxt = slot_r + 1'b1;
          flush = (slot_r == SW'(NDW - 1)) || (rem_r == 11'h1);
          if (rem_r == 11'h1) begin
            last = 1'b1;
            cq_state_nxt = CQ_IDLE;
          end
        end
      end
      default: cq_state_nxt = CQ_IDLE;
    endcase
    if (place) begin
      acc_data_nxt[32*slot_r +: 32] = dw;
      acc_keep_nxt[slot_r] = 1'b1;
    end
    // Beat leaves only on valid and ready; framing never runs into a held beat
    if (flush) begin
      out_data_nxt = acc_data_nxt;
      out_keep_nxt = acc_keep_nxt;
      out_last_nxt = last;
      out_valid_nxt = 1'b1;
      acc_data_nxt = '0;
      acc_keep_nxt = '0;
    end else if (out_valid_r && cq_tready_in) begin
      out_valid_nxt = 1'b0;
    end
    p_ready_nxt = (cq_state_nxt == CQ_TAKE) && !take_np_nxt;
    np_ready_nxt = (cq_state_nxt == CQ_TAKE) && take_np_nxt;
    // Ready is registered, so it is only raised when the held beat is gone
    pld_ready_nxt = (cq_state_nxt == CQ_PAY) && !out_valid_nxt;
  end

  // Framing registers
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cq_state_r <= CQ_IDLE;
      cur_r <= '0;
      take_np_r <= 1'b0;
      idx_r <= 2'h0;
      slot_r <= '0;
      rem_r <= 11'h0;
      acc_data_r <= '0;
      acc_keep_r <= '0;
      out_data_r <= '0;
      out_keep_r <= '0;
      out_last_r <= 1'b0;
      out_valid_r <= 1'b0;
      credit_r <= cqf_pkg::CREDIT_RST;
      p_ready_r <= 1'b0;
      np_ready_r <= 1'b0;
      pld_ready_r <= 1'b0;
    end else begin
      cq_state_r <= cq_state_nxt;
      cur_r <= cur_nxt;
      take_np_r <= take_np_nxt;
      idx_r <= idx_nxt;
      slot_r <= slot_nxt;
      rem_r <= rem_nxt;
      acc_data_r <= acc_data_nxt;
      acc_keep_r <= acc_keep_nxt;
      out_data_r <= out_data_nxt;
      out_keep_r <= out_keep_nxt;
      out_last_r <= out_last_nxt;
      out_valid_r <= out_valid_nxt;
      credit_r <= credit_nxt;
      p_ready_r <= p_ready_nxt;
      np_ready_r <= np_ready_nxt;
      pld_ready_r <= pld_ready_nxt;
    end
  end

  // Transmit merge: whole packets, round robin, each port kept in order
  cqf_tx_state_t tx_state_r, tx_state_nxt;
  logic last_rq_r, last_rq_nxt;
  logic [DATA_W-1:0] tx_data_r, tx_data_nxt;
  logic tx_last_r, tx_last_nxt, tx_valid_r, tx_valid_nxt;
  logic rq_ready_r, rq_ready_nxt, cc_ready_r, cc_ready_nxt;
  logic [3:0] tag_r, tag_nxt;
  logic tag_vld_r, tag_vld_nxt;
  logic take_rq, take_cc;

  always_comb begin
    tx_state_nxt = tx_state_r;
    last_rq_nxt = last_rq_r;
    tx_data_nxt = tx_data_r;
    tx_last_nxt = tx_last_r;
    tx_valid_nxt = tx_valid_r && !tx_tready_in;
    tag_nxt = tag_r;
    tag_vld_nxt = 1'b0;
    take_rq = rq_tvalid_in && rq_ready_r;
    take_cc = cc_tvalid_in && cc_ready_r;
    unique case (tx_state_r)
      TX_IDLE: begin
        if (rq_tvalid_in && (!cc_tvalid_in || !last_rq_r)) begin
          tx_state_nxt = TX_RQ;
        end else if (cc_tvalid_in) begin
          tx_state_nxt = TX_CC;
        end
      end
      TX_RQ: begin
        if (take_rq) begin
          tx_data_nxt = rq_tdata_in;
          tx_last_nxt = rq_tlast_in;
          tx_valid_nxt = 1'b1;
          if (rq_tlast_in) begin
            // Packet sits in the merged stream; no later completion can pass it
            tag_nxt = rq_order_tag_in;
            tag_vld_nxt = 1'b1;
            last_rq_nxt = 1'b1;
            tx_state_nxt = TX_IDLE;
          end
        end
      end
      TX_CC: begin
        if (take_cc) begin
          tx_data_nxt = cc_tdata_in;
          tx_last_nxt = cc_tlast_in;
          tx_valid_nxt = 1'b1;
          if (cc_tlast_in) begin
            last_rq_nxt = 1'b0;
            tx_state_nxt = TX_IDLE;
          end
        end
      end
      default: tx_state_nxt = TX_IDLE;
    endcase
    rq_ready_nxt = (tx_state_nxt == TX_RQ) && !tx_valid_nxt;
    cc_ready_nxt = (tx_state_nxt == TX_CC) && !tx_valid_nxt;
  end

  // Transmit registers
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_r <= TX_IDLE;
      last_rq_r <= 1'b0;
      tx_data_r <= '0;
      tx_last_r <= 1'b0;
      tx_valid_r <= 1'b0;
      rq_ready_r <= 1'b0;
      cc_ready_r <= 1'b0;
      tag_r <= 4'h0;
      tag_vld_r <= 1'b0;
    end else begin
      tx_state_r <= tx_state_nxt;
      last_rq_r <= last_rq_nxt;
      tx_data_r <= tx_data_nxt;
      tx_last_r <= tx_last_nxt;
      tx_valid_r <= tx_valid_nxt;
      rq_ready_r <= rq_ready_nxt;
      cc_ready_r <= cc_ready_nxt;
      tag_r <= tag_nxt;
      tag_vld_r <= tag_vld_nxt;
    end
  end

  // Outputs straight from registers
  assign hdr_p_ready_out = p_ready_r;
  assign hdr_np_ready_out = np_ready_r;
  assign pld_ready_out = pld_ready_r;
  assign pld_np_out = take_np_r;
  assign cq_tdata_out = out_data_r;
  assign cq_tkeep_out = out_keep_r;
  assign cq_tlast_out = out_last_r;
  assign cq_tvalid_out = out_valid_r;
  assign np_credit_out = credit_r;
  assign rq_tready_out = rq_ready_r;
  assign cc_tready_out = cc_ready_r;
  assign tx_tdata_out = tx_data_r;
  assign tx_tlast_out = tx_last_r;
  assign tx_tvalid_out = tx_valid_r;
  assign request_order_tag_out = tag_r;
  assign request_order_tag_valid = tag_vld_r;
endmodule : cqf_top

/* rtl/cqf_pkg.sv */
package cqf_pkg;
  // Completer request descriptor geometry
  localparam int DESC_DW = 4;
  localparam int DW_BITS = 32;
  // Descriptor field positions
  localparam int AT_LSB = 0;
  localparam int ADDR_LSB = 2;
  localparam int DWCNT_LSB = 64;
  localparam int TYPE_LSB = 75;
  localparam int REQID_LSB = 80;
  localparam int TAG_LSB = 96;
  localparam int TGT_LSB = 104;
  localparam int CODE_LSB = 104;
  localparam int ROUTE_LSB = 112;
  // Request type codes carried in the descriptor
  localparam logic [3:0] RT_MEM_RD = 4'h0;
  localparam logic [3:0] RT_MEM_WR = 4'h1;
  localparam logic [3:0] RT_IO_RD = 4'h2;
  localparam logic [3:0] RT_IO_WR = 4'h3;
  localparam logic [3:0] RT_ATOM_FA = 4'h4;
  localparam logic [3:0] RT_ATOM_SWP = 4'h5;
  localparam logic [3:0] RT_ATOM_CAS = 4'h6;
  localparam logic [3:0] RT_MEM_LK = 4'h7;
  localparam logic [3:0] RT_MSG = 4'hc;
  localparam logic [3:0] RT_MSG_VD = 4'hd;
  localparam logic [3:0] RT_MSG_ATS = 4'he;
  // Non-posted credit counter
  localparam int CREDIT_W = 6;
  localparam logic [5:0] CREDIT_RST = 6'h00;
  localparam logic [5:0] CREDIT_MAX = 6'h3f;

  // Request header as handed over by the receive path
  typedef struct packed {
    logic [7:0] seq;
    logic [3:0] rtype;
    logic [63:0] addr;
    logic [1:0] remap_type_bits;
    logic [10:0] dwcnt;
    logic [15:0] reqid;
    logic [7:0] tag;
    logic [16:0] target;
    logic [63:0] msg;
    logic [7:0] code;
    logic [2:0] route;
  } cqf_hdr_t;
  localparam int HDR_W = $bits(cqf_hdr_t);
endpackage : cqf_pkg

/* rtl/cqf_desc_if.sv */
`timescale 1ns/1ns
// Header in, formatted descriptor and request class out
interface cqf_desc_if;
  cqf_pkg::cqf_hdr_t hdr;
  logic [127:0] desc;
  logic np;
  logic has_data;
  logic has_addr;
  modport fmt (input hdr, output desc, output np, output has_data, output has_addr);
  modport user (output hdr, input desc, input np, input has_data, input has_addr);
endinterface : cqf_desc_if

/* rtl/cqf_desc_fmt.sv */
`timescale 1ns/1ns
module cqf_desc_fmt (
  cqf_desc_if.fmt d
);
  // Descriptor layout chosen by request class
  always_comb begin
    cqf_pkg::cqf_hdr_t h;
    h = d.hdr;
    d.desc = '0;
    d.desc[cqf_pkg::DWCNT_LSB +: 11] = h.dwcnt;
    d.desc[cqf_pkg::TYPE_LSB +: 4] = h.rtype;
    d.desc[cqf_pkg::REQID_LSB +: 16] = h.reqid;
    d.desc[cqf_pkg::TAG_LSB +: 8] = h.tag;
    unique case (h.rtype)
      cqf_pkg::RT_MSG_VD: begin
        d.desc[63:0] = h.msg;
        d.desc[cqf_pkg::CODE_LSB +: 8] = h.code;
        d.desc[cqf_pkg::ROUTE_LSB +: 3] = h.route;
      end
      cqf_pkg::RT_MSG_ATS: begin
        d.desc[63:0] = h.msg; // ATS messages carry no routing field
        d.desc[cqf_pkg::CODE_LSB +: 8] = h.code;
      end
      cqf_pkg::RT_MSG: begin
        d.desc[cqf_pkg::CODE_LSB +: 8] = h.code;
        d.desc[cqf_pkg::ROUTE_LSB +: 3] = h.route;
      end
      default: begin
        d.desc[cqf_pkg::AT_LSB +: 2] = h.remap_type_bits;
        d.desc[63:cqf_pkg::ADDR_LSB] = h.addr[63:2];
        d.desc[cqf_pkg::TGT_LSB +: 17] = h.target;
      end
    endcase
  end

  // Request class decode
  assign d.has_addr = (h_type_lt8(d.hdr.rtype));
  assign d.np = (d.hdr.rtype != cqf_pkg::RT_MEM_WR) && h_type_lt8(d.hdr.rtype);
  assign d.has_data = !(d.hdr.rtype inside {cqf_pkg::RT_MEM_RD, cqf_pkg::RT_IO_RD,
                                             cqf_pkg::RT_MEM_LK});

  function automatic logic h_type_lt8(input logic [3:0] t);
    h_type_lt8 = !t[3];
  endfunction : h_type_lt8
endmodule : cqf_desc_fmt

/* tb/cqf_top_props.sv */
`timescale 1ns/1ns
// Port-level checks beside the framer top
module cqf_top_props #(
  parameter int DATA_W = 128
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Headers and credit
  input wire logic hdr_p_valid_in,
  input wire logic hdr_p_ready_out,
  input wire logic hdr_np_ready_out,
  input wire logic [cqf_pkg::CREDIT_W-1:0] np_credit_out,
  // Completer request port
  input wire logic [DATA_W-1:0] cq_tdata_out,
  input wire logic cq_tlast_out,
  input wire logic cq_tvalid_out,
  input wire logic cq_tready_in,
  // Transmit side
  input wire logic rq_tlast_in,
  input wire logic rq_tvalid_in,
  input wire logic [3:0] rq_order_tag_in,
  input wire logic rq_tready_out,
  input wire logic cc_tready_out,
  input wire logic [DATA_W-1:0] tx_tdata_out,
  input wire logic tx_tvalid_out,
  input wire logic tx_tready_in,
  input wire logic [3:0] request_order_tag_out,
  input wire logic request_order_tag_valid
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Steps of a tagged request: last beat taken, then the echo
  sequence rq_last_taken;
    rq_tvalid_in && rq_tready_out && rq_tlast_in;
  endsequence
  sequence tag_echoed;
    request_order_tag_valid && request_order_tag_out == $past(rq_order_tag_in);
  endsequence
  AST_TAG_ECHO: assert property (rq_last_taken |=> tag_echoed)
    else $error("order tag not echoed");
  AST_TAG_PULSE: assert property (request_order_tag_valid |=> !request_order_tag_valid)
    else $error("tag valid too long");
  AST_TAG_HOLD: assert property (!request_order_tag_valid |-> $stable(request_order_tag_out))
    else $error("tag moved without valid");
  AST_CQ_HOLD: assert property (cq_tvalid_out && !cq_tready_in |=>
    cq_tvalid_out && $stable(cq_tdata_out) && $stable(cq_tlast_out))
    else $error("stalled request beat changed");
  AST_TX_HOLD: assert property (tx_tvalid_out && !tx_tready_in |=>
    tx_tvalid_out && $stable(tx_tdata_out))
    else $error("stalled transmit beat changed");
  AST_NP_CREDIT: assert property ($rose(hdr_np_ready_out) |-> $past(np_credit_out) != '0)
    else $error("non-posted taken without credit");
  AST_ONE_PORT: assert property (!(rq_tready_out && cc_tready_out))
    else $error("both transmit ports ready");
  AST_HDR_ONCE: assert property (hdr_p_ready_out |-> hdr_p_valid_in ##1 !hdr_p_ready_out)
    else $error("posted header ready misbehaved");
endmodule : cqf_top_props

bind cqf_top cqf_top_props #(.DATA_W(DATA_W)) u_props (
  .core_clk_in, .rstn_in, .hdr_p_valid_in, .hdr_p_ready_out, .hdr_np_ready_out,
  .np_credit_out, .cq_tdata_out, .cq_tlast_out, .cq_tvalid_out, .cq_tready_in,
  .rq_tlast_in, .rq_tvalid_in, .rq_order_tag_in, .rq_tready_out, .cc_tready_out,
  .tx_tdata_out, .tx_tvalid_out, .tx_tready_in, .request_order_tag_out,
  .request_order_tag_valid
);

/* tb/cqf_user_model.sv */
`timescale 1ns/1ns
// User-side sink of the request stream and source of credit
module cqf_user_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Bench controls
  input wire logic slow_in,
  input wire logic grant_in,
  // Completer request stream
  input wire logic [127:0] cq_tdata_in,
  input wire logic [3:0] cq_tkeep_in,
  input wire logic cq_tlast_in,
  input wire logic cq_tvalid_in,
  output logic cq_tready_out,
  output logic grant_out,
  // Last packet seen
  output logic [127:0] desc_out,
  output logic [127:0] data_out,
  output logic [3:0] keep_out,
  output int pkts_out
);
  logic first_r;
  // Slow mode refuses every other cycle so stalls land mid-packet
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cq_tready_out <= 1'b0;
      grant_out <= 1'b0;
      first_r <= 1'b1;
      pkts_out <= 0;
    end else begin
      cq_tready_out <= slow_in ? !cq_tready_out : 1'b1;
      grant_out <= grant_in;
      if (cq_tvalid_in && cq_tready_out) begin
        if (first_r) desc_out <= cq_tdata_in;
        data_out <= cq_tdata_in;
        keep_out <= cq_tkeep_in;
        first_r <= cq_tlast_in;
        if (cq_tlast_in) pkts_out <= pkts_out + 1;
      end
    end
  end
endmodule : cqf_user_model

/* tb/cqf_top_test.sv */
`timescale 1ns/1ns
module cqf_top_test;
  // Stimulus
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic align_addr_in = 1'b0;
  logic hdr_p_valid_in = 1'b0;
  logic hdr_np_valid_in = 1'b0;
  cqf_pkg::cqf_hdr_t hdr_p = '0;
  cqf_pkg::cqf_hdr_t hdr_np = '0;
  logic pld_valid_in = 1'b0;
  logic [31:0] pld_data_in = 32'h0;
  logic [127:0] rq_tdata_in = '0, cc_tdata_in = '0;
  logic rq_tlast_in = 1'b1, rq_tvalid_in = 1'b0, cc_tlast_in = 1'b1, cc_tvalid_in = 1'b0;
  logic [3:0] rq_order_tag_in = 4'h0;
  logic tx_tready_in = 1'b0, slow = 1'b0, grant = 1'b0;
  // Observed
  logic hdr_p_ready_out, hdr_np_ready_out, pld_ready_out, cq_tlast_out, cq_tvalid_out;
  logic cq_tready_in, grant_w, rq_tready_out, cc_tready_out, tx_tlast_out, tx_tvalid_out;
  logic request_order_tag_valid, pld_np_out;
  logic [127:0] cq_tdata_out, tx_tdata_out, desc, data;
  logic [3:0] cq_tkeep_out, keep, request_order_tag_out;
  logic [5:0] np_credit_out;
  int pkts, errors = 0, n_tests = 0, cycles = 0;
  logic [127:0] tx_q[$];

  cqf_top dut (
    .core_clk_in, .rstn_in, .align_addr_in,
    .hdr_p_valid_in, .hdr_p_in(hdr_p), .hdr_p_ready_out,
    .hdr_np_valid_in, .hdr_np_in(hdr_np), .hdr_np_ready_out,
    .pld_valid_in, .pld_data_in, .pld_ready_out, .pld_np_out,
    .cq_tdata_out, .cq_tkeep_out, .cq_tlast_out, .cq_tvalid_out, .cq_tready_in,
    .nonposted_credit_grant_in(grant_w), .np_credit_out,
    .rq_tdata_in, .rq_tlast_in, .rq_tvalid_in, .rq_order_tag_in, .rq_tready_out,
    .cc_tdata_in, .cc_tlast_in, .cc_tvalid_in, .cc_tready_out,
    .tx_tdata_out, .tx_tlast_out, .tx_tvalid_out, .tx_tready_in,
    .request_order_tag_out, .request_order_tag_valid
  );
  cqf_user_model partner (
    .core_clk_in, .rstn_in, .slow_in(slow), .grant_in(grant),
    .cq_tdata_in(cq_tdata_out), .cq_tkeep_in(cq_tkeep_out), .cq_tlast_in(cq_tlast_out),
    .cq_tvalid_in(cq_tvalid_out), .cq_tready_out(cq_tready_in), .grant_out(grant_w),
    .desc_out(desc), .data_out(data), .keep_out(keep), .pkts_out(pkts)
  );

  // Clock, transmit capture and hang guard
  initial forever #50 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    if (tx_tvalid_out && tx_tready_in) tx_q.push_back(tx_tdata_out);
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic cqf_pkg::cqf_hdr_t mk(logic [3:0] rt, logic [1:0] at, logic [7:0] sq);
    cqf_pkg::cqf_hdr_t h;
    h = '0;
    h.rtype = rt;
    h.addr = 64'h8;
    h.remap_type_bits = at;
    h.seq = sq;
    h.dwcnt = 11'h001;
    h.msg = 64'h0123456789abcdef;
    return h;
  endfunction : mk

  // Posted header plus its single payload dword, both held until taken
  task automatic post(cqf_pkg::cqf_hdr_t h, logic [31:0] d);
    hdr_p <= h;
    hdr_p_valid_in <= 1'b1;
    pld_data_in <= d;
    pld_valid_in <= 1'b1;
    do @(posedge core_clk_in); while (!hdr_p_ready_out);
    hdr_p_valid_in <= 1'b0;
    do @(posedge core_clk_in); while (!pld_ready_out);
    pld_valid_in <= 1'b0;
  endtask : post

  // Every layout but the ATS message one, and both alignment modes; messages align as address zero
  task automatic t_align();
    logic [3:0] rt[6];
    int s;
    rt = '{cqf_pkg::RT_MEM_WR, cqf_pkg::RT_ATOM_FA, cqf_pkg::RT_MEM_WR,
           cqf_pkg::RT_ATOM_SWP, cqf_pkg::RT_MSG_VD, cqf_pkg::RT_MSG};
    for (int i = 0; i < 6; i++) begin
      align_addr_in <= (i > 3) || i[0];
      slow <= i[0];
      post(mk(rt[i], i[1:0], 8'(i)), 32'hc0de0000 + i);
      wait (pkts == i + 1);
      @(posedge core_clk_in);
      s = (i < 4 && i[0]) ? 2 : 0;
      check("type", desc[78:75], rt[i]);
      check("p source", pld_np_out, 1'b0);
      check("keep", keep, 4'h1 << s);
      check("payload", data[s*32 +: 32], 32'hc0de0000 + i);
      if (i < 4) check("remap", desc[1:0], i[1:0]);
      if (i == 4) check("vendor msg", desc[63:0], 64'h0123456789abcdef);
    end
  endtask : t_align

  // An older read waits for credit while a posted write goes past it
  task automatic t_credit();
    hdr_np <= mk(cqf_pkg::RT_MEM_RD, 2'h0, 8'h10);
    hdr_np_valid_in <= 1'b1;
    post(mk(cqf_pkg::RT_MEM_WR, 2'h0, 8'h11), 32'h5a5a5a5a);
    repeat (20) @(posedge core_clk_in);
    check("posted only", pkts, 7);
    grant <= 1'b1;
    @(posedge core_clk_in);
    grant <= 1'b0;
    do @(posedge core_clk_in); while (!hdr_np_ready_out);
    hdr_np_valid_in <= 1'b0;
    wait (pkts == 8);
    @(posedge core_clk_in);
    check("np type", desc[78:75], cqf_pkg::RT_MEM_RD);
    check("np source", pld_np_out, 1'b1);
    check("credit", np_credit_out, 6'h00);
  endtask : t_credit

  // Tagged request under transmit stall, then a completion held back for the tag
  task automatic t_order();
    rq_tdata_in <= {4{32'h1234abcd}};
    rq_order_tag_in <= 4'h9;
    rq_tvalid_in <= 1'b1;
    do @(posedge core_clk_in); while (!rq_tready_out);
    rq_tvalid_in <= 1'b0;
    // Nothing ordered behind the request, completion or message, starts before the tag
    do @(posedge core_clk_in); while (!request_order_tag_valid);
    check("order tag", request_order_tag_out, 4'h9);
    tx_tready_in <= 1'b1;
    cc_tdata_in <= {4{32'hfeed0001}};
    cc_tvalid_in <= 1'b1;
    do @(posedge core_clk_in); while (!cc_tready_out);
    cc_tvalid_in <= 1'b0;
    wait (tx_q.size() == 2);
    check("tx first", tx_q[0], {4{32'h1234abcd}});
    check("tx second", tx_q[1], {4{32'hfeed0001}});
  endtask : t_order

  task automatic print_verdict();
    $display("Checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    check("credit at reset", np_credit_out, 6'h00);
    check("cq idle at reset", cq_tvalid_out, 1'b0);
    t_align();
    t_credit();
    t_order();
    print_verdict();
  end
endmodule : cqf_top_test
